//--- tbd_pkg.sv
// tbd_pkg: constants and types shared by the touch decision block
// assumes 32-bit APB data, byte addresses on an 8-bit address bus
package tbd_pkg;

  // sizes
  localparam int NUM_SENSORS = 4;
  localparam int SEL_W = 2;
  localparam int RAW_W = 16;
  localparam int DIFF_W = RAW_W + 1;
  localparam int BKT_W = RAW_W + 1;
  localparam int RES_W = 5;
  localparam int PARAM_W = 8;
  localparam int ADDR_W = 8;
  localparam int EVT_W = 3 * NUM_SENSORS;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] TOUCH_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] QUIET_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] BUCKET_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] HYST_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] DEBOUNCE_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] DIP_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] DIP_CNT_OFF = 8'h1c;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h20;
  localparam logic [ADDR_W-1:0] MASK_OFF = 8'h24;
  localparam logic [ADDR_W-1:0] ON_OFF = 8'h28;
  localparam logic [ADDR_W-1:0] BASE0_OFF = 8'h40;
  localparam logic [ADDR_W-1:0] DIFF0_OFF = 8'h60;
  localparam logic [ADDR_W-1:0] SLOT_STEP = 8'h04;

  // field positions
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_RES_LSB = 8;
  localparam int EVT_ON_LSB = 0;
  localparam int EVT_OFF_LSB = NUM_SENSORS;
  localparam int EVT_REBASE_LSB = 2 * NUM_SENSORS;

  // reset values
  localparam logic AUTO_RST = 1'b1;
  localparam logic [RES_W-1:0] RES_RST = 5'h09;
  localparam logic [PARAM_W-1:0] TOUCH_RST = 8'h28;
  localparam logic [PARAM_W-1:0] QUIET_RST = 8'h14;
  localparam logic [PARAM_W-1:0] BUCKET_RST = 8'hc8;
  localparam logic [PARAM_W-1:0] HYST_RST = 8'h0a;
  localparam logic [PARAM_W-1:0] DEBOUNCE_RST = 8'h03;
  localparam logic [PARAM_W-1:0] DIP_RST = 8'h14;
  localparam logic [PARAM_W-1:0] DIP_CNT_RST = 8'h0a;
  localparam logic [EVT_W-1:0] MASK_RST = 12'h000;

  typedef struct packed {
    logic autorebase;
    logic [RES_W-1:0] res;
    logic [PARAM_W-1:0] touch_level;
    logic [PARAM_W-1:0] quiet_band_limit;
    logic [PARAM_W-1:0] drift_bucket_limit;
    logic [PARAM_W-1:0] hyst;
    logic [PARAM_W-1:0] debounce;
    logic [PARAM_W-1:0] negative_dip_limit;
    logic [PARAM_W-1:0] dip_reset_samples;
  } cfg_t;

  typedef struct packed {
    logic [RAW_W-1:0] base;
    logic [BKT_W-1:0] bucket;
    logic signed [DIFF_W-1:0] diff;
    logic [PARAM_W-1:0] deb;
    logic [PARAM_W-1:0] low;
    logic on;
    logic seen;
    logic blocked;
  } sensor_t;

endpackage

//--- tbd_raw_range.sv
// tbd_raw_range: full-scale code for the selected resolution and raw clipping
// assumes the raw count is already synchronous to the block clock
`timescale 1ns/1ps
module tbd_raw_range
  import tbd_pkg::*;
(
  // conversion result and resolution
  input wire logic [RAW_W-1:0] raw_in,
  input wire logic [RES_W-1:0] res,
  // clipped result and full-scale code
  output logic [RAW_W-1:0] raw_out,
  output logic [RAW_W-1:0] full_scale
);

  // a resolution above the datapath width saturates to all ones
  always_comb begin
    full_scale = RAW_W'((17'h00001 << res) - 17'h00001);
    raw_out = (raw_in > full_scale) ? full_scale : raw_in;
  end

endmodule // tbd_raw_range

//--- tbd_irq.sv
// tbd_irq: sticky event status, mask and one level interrupt
// assumes clear bits come from a status read that has been answered
`timescale 1ns/1ps
module tbd_irq
  import tbd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events and software access
  input wire logic [EVT_W-1:0] set_evt,
  input wire logic [EVT_W-1:0] clr_evt,
  input wire logic mask_we,
  input wire logic [EVT_W-1:0] mask_wdata,
  // state
  output logic [EVT_W-1:0] status,
  output logic [EVT_W-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic irq;
  } irq_state_t;

  irq_state_t s_q;
  irq_state_t s_d;

  // a new event in the clearing cycle survives the clear
  always_comb begin
    s_d = s_q;
    s_d.status = (s_q.status & ~clr_evt) | set_evt;
    if (mask_we) begin
      s_d.mask = mask_wdata;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{status: '0, mask: MASK_RST, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign mask = s_q.mask;
  assign irq = s_q.irq;

endmodule // tbd_irq

//--- touch_baseline_decision.sv
// touch_baseline_decision: per-sensor baseline tracking and touch decision
// assumes one raw count per completed conversion, tagged with its sensor,
// and an APB master for the configuration and status registers
//
// What this block does
// - difference is raw count minus baseline
// - slow falls pull baseline down to raw
// - deep dip freezes baseline, starts low counter
// - long enough dip resets baseline to raw
// - short dips leave baseline held
// - touch on after debounce samples above upper level
// - touch off at once below lower level
// - short positive spikes keep sensor off
// - bucket updates only inside quiet band, or while touched with autorebase on
// - bucket reaching limit moves the baseline
// - autorebase keeps bucket running while touched
// - autorebase blocks detection until baseline reset
// - raw range is two to the resolution
`timescale 1ns/1ps
module touch_baseline_decision
  import tbd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter results
  input wire logic raw_valid,
  input wire logic [SEL_W-1:0] raw_sel,
  input wire logic [RAW_W-1:0] raw_count,
  // decisions
  output logic [NUM_SENSORS-1:0] sensor_on,
  output logic irq
);

  typedef struct packed {
    cfg_t cfg;
    sensor_t [NUM_SENSORS-1:0] sns;
    logic [31:0] rdata;
    logic slverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  // widen an unsigned threshold into the signed difference domain
  function automatic logic signed [DIFF_W-1:0] thr(input logic [PARAM_W-1:0] v);
    thr = $signed({{(DIFF_W-PARAM_W){1'b0}}, v});
  endfunction

  // offsets software may write
  function automatic logic is_writable(input logic [ADDR_W-1:0] a);
    is_writable = (a == CTRL_OFF) || (a == TOUCH_OFF) || (a == QUIET_OFF) ||
                  (a == BUCKET_OFF) || (a == HYST_OFF) || (a == DEBOUNCE_OFF) ||
                  (a == DIP_OFF) || (a == DIP_CNT_OFF) || (a == MASK_OFF);
  endfunction

  // offset of one per-sensor slot
  function automatic logic [ADDR_W-1:0] slot(input logic [ADDR_W-1:0] first, input int idx);
    slot = first + ADDR_W'(idx) * SLOT_STEP;
  endfunction

  // status bit of one event kind for one sensor
  function automatic int evt_idx(input int lsb, input logic [SEL_W-1:0] sel);
    evt_idx = lsb + int'(sel);
  endfunction

  logic [RAW_W-1:0] raw_c;
  logic [RAW_W-1:0] full_scale;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  logic mask_we;
  logic setup;
  logic access;
  logic [31:0] rd_val;
  logic rd_hit;
  sensor_t cur;
  sensor_t nxt;
  logic signed [DIFF_W-1:0] d;
  logic [PARAM_W:0] lo_inc;
  logic [PARAM_W:0] deb_inc;
  logic [BKT_W-1:0] bsum;
  logic rebase;
  logic dip_deep;
  logic dip_done;
  logic in_quiet;
  logic bucket_full;
  logic above_on;
  logic below_off;
  logic deb_done;
  logic wr_ok;
  logic rd_ok;

  tbd_raw_range u_range (
    .raw_in(raw_count),
    .res(s_q.cfg.res),
    .raw_out(raw_c),
    .full_scale(full_scale)
  );

  tbd_irq u_irq (
    .clock(clock),
    .rst(rst),
    .set_evt(evt_set),
    .clr_evt(evt_clr),
    .mask_we(mask_we),
    .mask_wdata(pwdata[EVT_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign setup = psel && !penable;
  assign access = psel && penable;
  // an access refused in its setup cycle has no side effect
  assign wr_ok = access && pwrite && !s_q.slverr;
  assign rd_ok = access && !pwrite && !s_q.slverr;

  // read value, looked up in the setup cycle and held for the access
  always_comb begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    unique case (paddr)
      CTRL_OFF: begin
        rd_val[CTRL_AUTO_BIT] = s_q.cfg.autorebase;
        rd_val[CTRL_RES_LSB +: RES_W] = s_q.cfg.res;
      end
      TOUCH_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.touch_level;
      QUIET_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.quiet_band_limit;
      BUCKET_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.drift_bucket_limit;
      HYST_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.hyst;
      DEBOUNCE_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.debounce;
      DIP_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.negative_dip_limit;
      DIP_CNT_OFF: rd_val[PARAM_W-1:0] = s_q.cfg.dip_reset_samples;
      STATUS_OFF: rd_val[EVT_W-1:0] = irq_status;
      MASK_OFF: rd_val[EVT_W-1:0] = irq_mask;
      ON_OFF: rd_val[NUM_SENSORS-1:0] = sensor_on;
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_SENSORS; i++) begin
          if (paddr == slot(BASE0_OFF, i)) begin
            rd_val[RAW_W-1:0] = s_q.sns[i].base;
            rd_hit = 1'b1;
          end
          if (paddr == slot(DIFF0_OFF, i)) begin
            rd_val = 32'($signed(s_q.sns[i].diff));
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // software side effects in the completing access cycle
  always_comb begin
    mask_we = wr_ok && (paddr == MASK_OFF);
    evt_clr = '0;
    if (rd_ok && (paddr == STATUS_OFF)) begin
      // clear only what the read returned; later events stay set
      evt_clr = s_q.rdata[EVT_W-1:0];
    end
  end

  // arithmetic and threshold decisions for the sensor named by raw_sel;
  // each threshold comparison is made once here and used by the state step below
  always_comb begin
    cur = s_q.sns[raw_sel];
    d = $signed({1'b0, raw_c}) - $signed({1'b0, cur.base});
    lo_inc = {1'b0, cur.low} + 9'h001;
    deb_inc = {1'b0, cur.deb} + 9'h001;
    bsum = cur.bucket + BKT_W'($unsigned(d));
    // limits are unsigned bytes, widened so that every compare against the difference stays signed
    dip_deep = d < -thr(s_q.cfg.negative_dip_limit);
    dip_done = lo_inc >= {1'b0, s_q.cfg.dip_reset_samples};
    in_quiet = d < thr(s_q.cfg.quiet_band_limit);
    bucket_full = bsum >= {{(BKT_W-PARAM_W){1'b0}}, s_q.cfg.drift_bucket_limit};
    above_on = d > thr(s_q.cfg.touch_level) + thr(s_q.cfg.hyst);
    below_off = d < thr(s_q.cfg.touch_level) - thr(s_q.cfg.hyst);
    deb_done = deb_inc > {1'b0, s_q.cfg.debounce};
  end

  // per-sample step for the sensor named by raw_sel
  // the first sample seeds the baseline, a blocked sensor only counts, and
  // otherwise the baseline branch runs before the touch branch; a rebase in
  // this sample overrides both at the end
  always_comb begin
    nxt = cur;
    rebase = 1'b0;
    nxt.diff = d;
    if (!cur.seen) begin
      // first conversion after reset takes the raw count as baseline
      nxt.base = raw_c;
      nxt.diff = '0;
      nxt.seen = 1'b1;
    end else if (cur.blocked) begin
      // detection waits out the count whatever the difference does; this
      // acts as an extra debounce after a release with autorebase on
      nxt.on = 1'b0;
      nxt.deb = '0;
      if (dip_done) begin
        rebase = 1'b1;
        nxt.blocked = 1'b0;
      end else begin
        nxt.low = lo_inc[PARAM_W-1:0];
      end
    end else begin
      if (dip_deep) begin
        // baseline frozen while the dip lasts
        nxt.deb = '0;
        if (dip_done) begin
          rebase = 1'b1;
        end else begin
          nxt.low = lo_inc[PARAM_W-1:0];
        end
      end else begin
        nxt.low = '0;
        if (d <= 0) begin
          nxt.base = raw_c;
          nxt.bucket = '0;
        end else if (in_quiet ||
                     (s_q.cfg.autorebase && cur.on)) begin
          if (bucket_full) begin
            nxt.bucket = '0;
            // capped so a long touch cannot lift it past the clipped raw range
            if (cur.base < full_scale) begin
              nxt.base = cur.base + 16'h0001;
            end
          end else begin
            nxt.bucket = bsum;
          end
        end
      end
      if (cur.on) begin
        if (below_off) begin
          nxt.on = 1'b0;
          nxt.low = '0;
          nxt.blocked = s_q.cfg.autorebase;
        end
      end else if (!rebase && above_on) begin
        if (deb_done) begin
          nxt.on = 1'b1;
          nxt.deb = '0;
        end else begin
          nxt.deb = deb_inc[PARAM_W-1:0];
        end
      end else begin
        nxt.deb = '0;
      end
    end
    if (rebase) begin
      nxt.base = raw_c;
      nxt.low = '0;
      nxt.bucket = '0;
      nxt.deb = '0;
      nxt.on = 1'b0;
      nxt.diff = '0;
    end
  end

  // events of the stepped sensor; the irq block keeps them sticky
  always_comb begin
    evt_set = '0;
    if (raw_valid) begin
      evt_set[evt_idx(EVT_ON_LSB, raw_sel)] = nxt.on && !cur.on;
      evt_set[evt_idx(EVT_OFF_LSB, raw_sel)] = cur.on && !nxt.on;
      evt_set[evt_idx(EVT_REBASE_LSB, raw_sel)] = rebase;
    end
  end

  always_comb begin
    s_d = s_q;
    if (raw_valid) begin
      s_d.sns[raw_sel] = nxt;
    end
    if (setup) begin
      s_d.rdata = rd_hit ? rd_val : 32'h00000000;
      s_d.slverr = pwrite ? !is_writable(paddr) : !rd_hit;
    end
    if (wr_ok) begin
      unique case (paddr)
        CTRL_OFF: begin
          s_d.cfg.autorebase = pwdata[CTRL_AUTO_BIT];
          s_d.cfg.res = pwdata[CTRL_RES_LSB +: RES_W];
        end
        TOUCH_OFF: s_d.cfg.touch_level = pwdata[PARAM_W-1:0];
        QUIET_OFF: s_d.cfg.quiet_band_limit = pwdata[PARAM_W-1:0];
        BUCKET_OFF: s_d.cfg.drift_bucket_limit = pwdata[PARAM_W-1:0];
        HYST_OFF: s_d.cfg.hyst = pwdata[PARAM_W-1:0];
        DEBOUNCE_OFF: s_d.cfg.debounce = pwdata[PARAM_W-1:0];
        DIP_OFF: s_d.cfg.negative_dip_limit = pwdata[PARAM_W-1:0];
        DIP_CNT_OFF: s_d.cfg.dip_reset_samples = pwdata[PARAM_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.cfg <= '{
        autorebase: AUTO_RST,
        res: RES_RST,
        touch_level: TOUCH_RST,
        quiet_band_limit: QUIET_RST,
        drift_bucket_limit: BUCKET_RST,
        hyst: HYST_RST,
        debounce: DEBOUNCE_RST,
        negative_dip_limit: DIP_RST,
        dip_reset_samples: DIP_CNT_RST
      };
      // sensors restart unseen, so each one's first conversion seeds its baseline
      s_q.sns <= '0;
      s_q.rdata <= 32'h00000000;
      s_q.slverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // zero wait states: the answer was prepared in the setup cycle, at the
  // cost of a read data register that a late-changing value cannot refresh
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = access && s_q.slverr;

  generate
    for (genvar g = 0; g < NUM_SENSORS; g++) begin : g_on
      assign sensor_on[g] = s_q.sns[g].on;
    end
  endgenerate

endmodule // touch_baseline_decision

//--- tbd_props.sv
// tbd_props: port-level checks of the touch decision block
// assumes it is bound into touch_baseline_decision and sees only its ports
`timescale 1ns/1ps
module tbd_props
  import tbd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // conversions and decisions
  input wire logic raw_valid,
  input wire logic [SEL_W-1:0] raw_sel,
  input wire logic [NUM_SENSORS-1:0] sensor_on,
  input wire logic irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_err_access;
    pslverr |-> psel && penable;
  endproperty
  a_err_access: assert property (p_err_access) else $error("pslverr outside access");

  property p_err_zero;
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");

  property p_ro_write_err;
    psel && penable && pwrite && (paddr == STATUS_OFF || paddr == ON_OFF) |-> pslverr;
  endproperty
  a_ro_write_err: assert property (p_ro_write_err) else $error("read-only write accepted");

  property p_on_needs_sample;
    sensor_on != $past(sensor_on) |-> $past(raw_valid);
  endproperty
  a_on_needs_sample: assert property (p_on_needs_sample) else $error("state moved idle");

  // a sample may only move the state of the sensor it belongs to
  property p_on_own_bit;
    $past(raw_valid) |->
      ((sensor_on ^ $past(sensor_on)) & ~(NUM_SENSORS'(1) << $past(raw_sel))) == '0;
  endproperty
  a_on_own_bit: assert property (p_on_own_bit) else $error("other sensor changed");

  property p_on_read;
    psel && penable && !pwrite && paddr == ON_OFF && $stable(sensor_on)
      |-> prdata == 32'(sensor_on);
  endproperty
  a_on_read: assert property (p_on_read) else $error("on register differs");

  property p_irq_rise;
    $rose(irq) |-> $past(raw_valid) || ($past(pwrite) && $past(penable));
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");

  property p_irq_fall;
    $fell(irq) |-> $past(penable);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule // tbd_props

bind touch_baseline_decision tbd_props tbd_props_inst (.clock(clock), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .raw_valid(raw_valid), .raw_sel(raw_sel), .sensor_on(sensor_on),
  .irq(irq));

//--- tbd_conv_model.sv
// tbd_conv_model: converter model that hands one raw count per conversion
// assumes send is called just after a rising clock edge
`timescale 1ns/1ps
module tbd_conv_model
  import tbd_pkg::*;
(
  // clock
  input wire logic clock,
  // conversion results
  output logic raw_valid,
  output logic [SEL_W-1:0] raw_sel,
  output logic [RAW_W-1:0] raw_count
);
  initial begin
    raw_valid = 1'b0;
    raw_sel = '0;
    raw_count = '0;
  end

  // idle lines carry the inverse of the last code so a stale value is never taken
  task automatic send(input logic [SEL_W-1:0] s, input logic [RAW_W-1:0] r);
    raw_valid <= 1'b1;
    raw_sel <= s;
    raw_count <= r;
    @(posedge clock);
    raw_valid <= 1'b0;
    raw_sel <= ~s;
    raw_count <= ~r;
    @(posedge clock);
  endtask
endmodule // tbd_conv_model

//--- touch_baseline_decision_test.sv
// touch_baseline_decision_test: self-checking bench of the touch decision block
// assumes tbd_conv_model for conversions and tbd_props bound to the block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module touch_baseline_decision_test import tbd_pkg::*;;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, raw_valid, irq, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [SEL_W-1:0] raw_sel;
  logic [RAW_W-1:0] raw_count;
  logic [NUM_SENSORS-1:0] sensor_on;
  int err_count, total_checks;

  touch_baseline_decision touch_baseline_decision_inst (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid),
    .raw_sel(raw_sel), .raw_count(raw_count), .sensor_on(sensor_on), .irq(irq));
  tbd_conv_model tbd_conv_model_inst (.clock(clock), .raw_valid(raw_valid),
    .raw_sel(raw_sel), .raw_count(raw_count));

  task automatic test_done;
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic put(input logic [SEL_W-1:0] s, input logic [RAW_W-1:0] r, input int n);
    repeat (n) tbd_conv_model_inst.send(s, r);
  endtask

  task automatic t_reset;
    logic [31:0] exp [10] = '{32'h901, 32'h28, 32'h14, 32'hc8, 32'h0a, 32'h03, 32'h14,
      32'h0a, 32'h0, 32'h0};
    for (int i = 0; i < 10; i++) begin
      rchk("reset_val", ADDR_W'(4 * i), exp[i]);
    end
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_data", 32'h0, rd)
    apb(1'b1, STATUS_OFF, 32'hfff);
    `CHK("ro_write_err", 1'b1, er)
    `CHK("reset_on", 4'h0, sensor_on)
  endtask

  task automatic t_touch;
    apb(1'b1, CTRL_OFF, 32'h900);
    for (int s = 0; s < 4; s++) put(SEL_W'(s), 16'd100, 1);
    rchk("base0", BASE0_OFF, 32'd100);
    put(0, 16'd151, 3);
    `CHK("on_early", 4'h0, sensor_on)
    rchk("diff0", DIFF0_OFF, 32'd51);
    put(0, 16'd151, 1);
    `CHK("on_deb", 4'h1, sensor_on)
    rchk("on_reg", ON_OFF, 32'h1);
    put(1, 16'd151, 3);
    put(1, 16'd100, 1);
    `CHK("spike", 4'h1, sensor_on)
    put(0, 16'd131, 1);
    `CHK("hyst_hold", 4'h1, sensor_on)
    put(0, 16'd129, 1);
    `CHK("off_now", 4'h0, sensor_on)
  endtask

  task automatic t_dip;
    put(2, 16'd95, 1);
    rchk("slow_fall", BASE0_OFF + 8'h08, 32'd95);
    apb(1'b0, STATUS_OFF, 32'h0);
    apb(1'b1, MASK_OFF, 32'h400);
    put(2, 16'd70, 9);
    rchk("dip_hold", BASE0_OFF + 8'h08, 32'd95);
    rchk("dip_diff", DIFF0_OFF + 8'h08, 32'hffffffe7);
    `CHK("irq_quiet", 1'b0, irq)
    put(2, 16'd95, 1);
    put(2, 16'd70, 9);
    rchk("spike_kept", BASE0_OFF + 8'h08, 32'd95);
    put(2, 16'd70, 1);
    rchk("dip_reset", BASE0_OFF + 8'h08, 32'd70);
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("evt_bit", 32'h400, rd & 32'h400)
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("evt_clear", 32'h0, rd & 32'h400)
    `CHK("irq_clear", 1'b0, irq)
  endtask

  task automatic t_bucket;
    apb(1'b1, BUCKET_OFF, 32'h0a);
    rchk("bucket_rw", BUCKET_OFF, 32'h0a);
    put(3, 16'd105, 1);
    rchk("bkt_part", BASE0_OFF + 8'h0c, 32'd100);
    put(3, 16'd105, 1);
    rchk("bkt_move", BASE0_OFF + 8'h0c, 32'd101);
    put(3, 16'd130, 5);
    rchk("bkt_quiet", BASE0_OFF + 8'h0c, 32'd101);
  endtask

  task automatic t_auto;
    apb(1'b1, CTRL_OFF, 32'h901);
    put(1, 16'd160, 4);
    `CHK("auto_on", 4'h2, sensor_on)
    put(1, 16'd160, 2);
    apb(1'b0, BASE0_OFF + 8'h04, 32'h0);
    `CHK("auto_grow", 1'b1, rd > 32'd100)
    put(1, 16'd100, 1);
    `CHK("auto_off", 4'h0, sensor_on)
    put(1, 16'd160, 8);
    `CHK("auto_block", 4'h0, sensor_on)
    put(1, 16'd160, 4);
    rchk("auto_rebase", BASE0_OFF + 8'h04, 32'd160);
  endtask

  task automatic t_clip;
    put(3, 16'h0fff, 1);
    rchk("clip9", DIFF0_OFF + 8'h0c, 32'h19a);
    apb(1'b1, CTRL_OFF, 32'hc01);
    put(3, 16'h0fff, 1);
    rchk("clip12", DIFF0_OFF + 8'h0c, 32'hf9a);
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // about 240 cycles of traffic; the margin only catches a hang
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_touch();
    t_dip();
    t_bucket();
    t_auto();
    t_clip();
    test_done();
  end
endmodule // touch_baseline_decision_test
